// File: verilog/adis_pkg.sv
package adis_pkg;

	// ------------------------------------------------------------
	// Bus geometry and register offsets.
	// ------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int PINS = 16;
	localparam int MUX_SEL_W = 4;
	localparam logic [ADR_W-1:0] OFS_CHS = 8'h00;
	localparam logic [ADR_W-1:0] OFS_CHS_CLR = 8'h04;
	localparam logic [ADR_W-1:0] OFS_CHS_SET = 8'h08;
	localparam logic [ADR_W-1:0] OFS_CHS_INV = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_PIN_KIND_BIT = 8'h10;
	localparam logic [ADR_W-1:0] OFS_PIN_KIND_BIT_CLR = 8'h14;
	localparam logic [ADR_W-1:0] OFS_PIN_KIND_BIT_SET = 8'h18;
	localparam logic [SEL_W-1:0] SEL_ALL = 4'hf;

	// ------------------------------------------------------------
	// Field layout and reset values.
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] CHS_MASK = 32'h8f8f_0000;
	localparam logic [DATA_W-1:0] PIN_KIND_BIT_MASK = 32'h0000_ffff;
	localparam logic [DATA_W-1:0] CHS_RESET = 32'h0000_0000;
	localparam logic [PINS-1:0] PIN_KIND_BIT_RESET = 16'h0000;
	localparam logic [PINS-1:0] PORT_READ_RESET = 16'hffff;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam int CHS_SA_LSB = 16;
	localparam int CHS_NA_BIT = 23;
	localparam int CHS_SB_LSB = 24;
	localparam int CHS_NB_BIT = 31;
	localparam int NEG_PIN = 1;

	typedef enum logic [1:0] {
		ADIS_OP_WRITE,
		ADIS_OP_CLR,
		ADIS_OP_SET,
		ADIS_OP_INV
	} adis_op_t;

	typedef struct packed {
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] chs;
		logic [PINS-1:0] pin_kind_bit;
	} adis_regs_state_t;

endpackage : adis_pkg

// File: verilog/adis_cfg_if.sv
`timescale 1ns/1ps
interface adis_cfg_if;
	import adis_pkg::*;

	logic [PINS-1:0] pin_kind;
	logic [MUX_SEL_W-1:0] first_pos;
	logic first_neg;
	logic [MUX_SEL_W-1:0] second_pos;
	logic second_neg;

	modport regs
	(
		output pin_kind,
		output first_pos,
		output first_neg,
		output second_pos,
		output second_neg
	);

	modport pins
	(
		input pin_kind,
		input first_pos,
		input first_neg,
		input second_pos,
		input second_neg
	);

endinterface : adis_cfg_if

// File: verilog/adis_pin_ctl.sv
`timescale 1ns/1ps
module adis_pin_ctl
(
	input wire logic clk_i,
	input wire logic rst_i,
	adis_cfg_if.pins cfg,
	input wire logic [adis_pkg::PINS-1:0] pin_level_i,
	output logic [adis_pkg::PINS-1:0] pin_digital_o,
	output logic [adis_pkg::PINS-1:0] port_read_o,
	output logic [adis_pkg::MUX_SEL_W-1:0] first_mux_positive_select_o,
	output logic first_mux_negative_select_o,
	output logic first_mux_ground_o,
	output logic [adis_pkg::MUX_SEL_W-1:0] second_mux_positive_select_o,
	output logic second_mux_negative_select_o,
	output logic second_mux_ground_o
);
	import adis_pkg::*;

	typedef struct packed {
		logic [PINS-1:0] sync1;
		logic [PINS-1:0] sync2;
		logic [PINS-1:0] digital;
		logic [PINS-1:0] port_rd;
		logic [MUX_SEL_W-1:0] a_pos;
		logic a_neg;
		logic a_gnd;
		logic [MUX_SEL_W-1:0] b_pos;
		logic b_neg;
		logic b_gnd;
	} adis_pin_state_t;

	adis_pin_state_t q;
	adis_pin_state_t next_q;

	// ------------------------------------------------------------
	// Pin mode, port read and multiplexer steering.
	// ------------------------------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.sync1 = pin_level_i;
		next_q.sync2 = q.sync1;
		next_q.digital = cfg.pin_kind;
		// Analog pins read as one; digital pins show the synced level.
		next_q.port_rd = q.sync2 | ~cfg.pin_kind;
		next_q.a_pos = cfg.first_pos;
		next_q.a_neg = cfg.first_neg;
		next_q.b_pos = cfg.second_pos;
		next_q.b_neg = cfg.second_neg;
		// A digital pin feeds ground into the converter input.
		next_q.a_gnd = cfg.pin_kind[cfg.first_pos];
		next_q.b_gnd = cfg.pin_kind[cfg.second_pos];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.port_rd <= PORT_READ_RESET;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign pin_digital_o = q.digital;
	assign port_read_o = q.port_rd;
	assign first_mux_positive_select_o = q.a_pos;
	assign first_mux_negative_select_o = q.a_neg;
	assign first_mux_ground_o = q.a_gnd;
	assign second_mux_positive_select_o = q.b_pos;
	assign second_mux_negative_select_o = q.b_neg;
	assign second_mux_ground_o = q.b_gnd;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	a_digital_follows: assert property
		(@(posedge clk_i) disable iff (rst_i)
		!$rose(rst_i) |=> pin_digital_o == $past(cfg.pin_kind))
		else $error("pin mode does not follow configuration");
	a_analog_reads_one: assert property
		(@(posedge clk_i) disable iff (rst_i)
		##1 ((~$past(cfg.pin_kind)) & ~port_read_o) == PIN_KIND_BIT_RESET)
		else $error("analog pin read is not one");
	a_port_read_sync: assert property
		(@(posedge clk_i) disable iff (rst_i)
		##3 ($past(cfg.pin_kind) & (port_read_o ^ $past(pin_level_i, 3)))
		== PIN_KIND_BIT_RESET)
		else $error("digital port read does not show the pin level");
	a_mux_ground: assert property
		(@(posedge clk_i) disable iff (rst_i)
		##1 first_mux_ground_o ==
		$past(cfg.pin_kind[cfg.first_pos]))
		else $error("first mux ground flag wrong");

endmodule : adis_pin_ctl

// File: verilog/adis_regs.sv
`timescale 1ns/1ps
// Function
// - Clear alias clears selection bits written one.
// - Set alias sets selection bits written one.
// - Invert alias toggles selection bits written one.
// - Zero bits in alias writes change nothing.
// - Aliases never touch unimplemented bits.
// - Alias reads return zero.
// - Sixteen pin kind bits, reset to zero.
// - One: digital pin, port read, mux grounded.
// - Zero: analog pin, port read gives one.
// - Upper pin kind bits reserved, write zero.
// - Pin kind clear alias clears ones.
// - Pin kind set alias sets ones.
module adis_regs
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [adis_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [adis_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [adis_pkg::DATA_W-1:0] wb_dat_i,
	output logic [adis_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [adis_pkg::PINS-1:0] pin_level_i,
	output logic [adis_pkg::PINS-1:0] pin_digital_o,
	output logic [adis_pkg::PINS-1:0] port_read_o,
	output logic [adis_pkg::MUX_SEL_W-1:0] first_mux_positive_select_o,
	output logic first_mux_negative_select_o,
	output logic first_mux_ground_o,
	output logic [adis_pkg::MUX_SEL_W-1:0] second_mux_positive_select_o,
	output logic second_mux_negative_select_o,
	output logic second_mux_ground_o
);
	import adis_pkg::*;

	adis_regs_state_t q;
	adis_regs_state_t next_q;
	logic req;
	logic [DATA_W-1:0] byte_mask;
	logic [DATA_W-1:0] pin_kind_bit_word;

	adis_cfg_if cfg ();

	// ------------------------------------------------------------
	// Decode helpers.
	// ------------------------------------------------------------
	function automatic logic [DATA_W-1:0] expand_sel
	(
		input logic [SEL_W-1:0] sel
	);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : expand_sel

	function automatic logic is_chs
	(
		input logic [ADR_W-1:0] adr
	);
		return adr == OFS_CHS || adr == OFS_CHS_CLR ||
			adr == OFS_CHS_SET || adr == OFS_CHS_INV;
	endfunction : is_chs

	function automatic logic is_pin_kind_bit
	(
		input logic [ADR_W-1:0] adr
	);
		return adr == OFS_PIN_KIND_BIT || adr == OFS_PIN_KIND_BIT_CLR ||
			adr == OFS_PIN_KIND_BIT_SET;
	endfunction : is_pin_kind_bit

	function automatic logic is_alias
	(
		input logic [ADR_W-1:0] adr
	);
		return adr == OFS_CHS_CLR || adr == OFS_CHS_SET ||
			adr == OFS_CHS_INV || adr == OFS_PIN_KIND_BIT_CLR ||
			adr == OFS_PIN_KIND_BIT_SET;
	endfunction : is_alias

	function automatic adis_op_t decode_op
	(
		input logic [ADR_W-1:0] adr
	);
		adis_op_t op;
		op = ADIS_OP_WRITE;
		if (adr == OFS_CHS_CLR || adr == OFS_PIN_KIND_BIT_CLR)
		begin
			op = ADIS_OP_CLR;
		end
		else if (adr == OFS_CHS_SET || adr == OFS_PIN_KIND_BIT_SET)
		begin
			op = ADIS_OP_SET;
		end
		else if (adr == OFS_CHS_INV)
		begin
			op = ADIS_OP_INV;
		end
		return op;
	endfunction : decode_op

	// Applies a plain write or an atomic alias to one register image.
	function automatic logic [DATA_W-1:0] apply_op
	(
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] dat,
		input logic [DATA_W-1:0] bm,
		input adis_op_t op,
		input logic [DATA_W-1:0] mask
	);
		logic [DATA_W-1:0] hit;
		logic [DATA_W-1:0] res;
		hit = dat & bm;
		res = cur;
		unique case (op)
			ADIS_OP_WRITE: res = (cur & ~bm) | hit;
			ADIS_OP_CLR: res = cur & ~hit;
			ADIS_OP_SET: res = cur | hit;
			ADIS_OP_INV: res = cur ^ hit;
		endcase
		return res & mask;
	endfunction : apply_op

	// Alias and unmapped reads answer with zero.
	function automatic logic [DATA_W-1:0] read_word
	(
		input logic [ADR_W-1:0] adr,
		input logic [DATA_W-1:0] chs,
		input logic [PINS-1:0] pin_kind_bit
	);
		logic [DATA_W-1:0] r;
		r = ZERO_WORD;
		if (adr == OFS_CHS)
		begin
			r = chs;
		end
		else if (adr == OFS_PIN_KIND_BIT)
		begin
			r = {{(DATA_W-PINS){1'b0}}, pin_kind_bit};
		end
		return r;
	endfunction : read_word

	// ------------------------------------------------------------
	// Wishbone slave and register file.
	// ------------------------------------------------------------
	assign req = wb_cyc_i & wb_stb_i;
	assign byte_mask = expand_sel(wb_sel_i);

	always_comb
	begin
		next_q = q;
		next_q.ack = 1'b0;
		pin_kind_bit_word = apply_op({{(DATA_W-PINS){1'b0}}, q.pin_kind_bit}, wb_dat_i,
			byte_mask, decode_op(wb_adr_i), PIN_KIND_BIT_MASK);
		// Every request, mapped or not, is answered one cycle later.
		if (req && !q.ack)
		begin
			next_q.ack = 1'b1;
			next_q.rdata = read_word(wb_adr_i, q.chs, q.pin_kind_bit);
			if (wb_we_i && is_chs(wb_adr_i))
			begin
				next_q.chs = apply_op(q.chs, wb_dat_i, byte_mask,
					decode_op(wb_adr_i), CHS_MASK);
			end
			if (wb_we_i && is_pin_kind_bit(wb_adr_i))
			begin
				next_q.pin_kind_bit = pin_kind_bit_word[PINS-1:0];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q.ack <= 1'b0;
			q.rdata <= ZERO_WORD;
			q.chs <= CHS_RESET;
			q.pin_kind_bit <= PIN_KIND_BIT_RESET;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdata;

	// ------------------------------------------------------------
	// Configuration towards the pins and multiplexers.
	// ------------------------------------------------------------
	assign cfg.pin_kind = q.pin_kind_bit;
	assign cfg.first_pos = q.chs[CHS_SA_LSB +: MUX_SEL_W];
	assign cfg.first_neg = q.chs[CHS_NA_BIT];
	assign cfg.second_pos = q.chs[CHS_SB_LSB +: MUX_SEL_W];
	assign cfg.second_neg = q.chs[CHS_NB_BIT];

	adis_pin_ctl u_pin_ctl
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cfg(cfg.pins),
		.pin_level_i(pin_level_i),
		.pin_digital_o(pin_digital_o),
		.port_read_o(port_read_o),
		.first_mux_positive_select_o(first_mux_positive_select_o),
		.first_mux_negative_select_o(first_mux_negative_select_o),
		.first_mux_ground_o(first_mux_ground_o),
		.second_mux_positive_select_o(second_mux_positive_select_o),
		.second_mux_negative_select_o(second_mux_negative_select_o),
		.second_mux_ground_o(second_mux_ground_o)
	);

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack) |=> wb_ack_o)
		else $error("request not answered in one cycle");

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_chs_clear: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && wb_adr_i == OFS_CHS_CLR &&
		wb_sel_i == SEL_ALL) |=>
		(q.chs & $past(wb_dat_i)) == ZERO_WORD)
		else $error("clear alias left a bit set");

	a_chs_set: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && wb_adr_i == OFS_CHS_SET &&
		wb_sel_i == SEL_ALL) |=>
		(q.chs & $past(wb_dat_i) & CHS_MASK) ==
		($past(wb_dat_i) & CHS_MASK))
		else $error("set alias left a bit clear");

	a_chs_invert: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && wb_adr_i == OFS_CHS_INV &&
		wb_sel_i == SEL_ALL) |=>
		(q.chs ^ $past(q.chs)) == ($past(wb_dat_i) & CHS_MASK))
		else $error("invert alias toggled the wrong bits");

	a_alias_zero_keep: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && is_alias(wb_adr_i)) |=>
		((q.chs ^ $past(q.chs)) & ~$past(wb_dat_i)) == ZERO_WORD &&
		((q.pin_kind_bit ^ $past(q.pin_kind_bit)) & ~$past(wb_dat_i[PINS-1:0]))
		== PIN_KIND_BIT_RESET)
		else $error("alias changed a bit written zero");

	a_unimpl_zero: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(q.chs & ~CHS_MASK) == ZERO_WORD)
		else $error("unimplemented selection bit became set");

	a_alias_read: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && !wb_we_i && is_alias(wb_adr_i)) |=>
		wb_ack_o && wb_dat_o == ZERO_WORD)
		else $error("alias read returned data");

	a_pin_kind_bit_reset: assert property
		(@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> q.pin_kind_bit == PIN_KIND_BIT_RESET && !wb_ack_o)
		else $error("pin kind not zero after reset");

	a_pin_kind_bit_read: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && !wb_we_i && wb_adr_i == OFS_PIN_KIND_BIT) |=>
		wb_dat_o == {16'h0000, $past(q.pin_kind_bit)})
		else $error("pin kind read back wrong");

	a_pin_kind_bit_clear: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && wb_adr_i == OFS_PIN_KIND_BIT_CLR &&
		wb_sel_i == SEL_ALL) |=>
		(q.pin_kind_bit & $past(wb_dat_i[PINS-1:0])) == PIN_KIND_BIT_RESET)
		else $error("pin kind clear alias failed");

	a_pin_kind_bit_set: assert property
		(@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack && wb_we_i && wb_adr_i == OFS_PIN_KIND_BIT_SET &&
		wb_sel_i == SEL_ALL) |=>
		(q.pin_kind_bit | ~$past(wb_dat_i[PINS-1:0])) == PORT_READ_RESET)
		else $error("pin kind set alias failed");

	a_idle_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> $stable(q.chs) && $stable(q.pin_kind_bit))
		else $error("register changed without a request");

	a_mux_fields: assert property
		(@(posedge clk_i) disable iff (rst_i)
		##2 first_mux_positive_select_o ==
		$past(q.chs[CHS_SA_LSB +: MUX_SEL_W]) &&
		second_mux_negative_select_o == $past(q.chs[CHS_NB_BIT]))
		else $error("mux select outputs do not follow the register");

endmodule : adis_regs

// File: tb/adis_regs_bench.sv
`timescale 1ns/1ps
module adis_regs_bench;
	import adis_pkg::*;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = 8'h00;
	logic [SEL_W-1:0] wb_sel_i = 4'h0;
	logic [DATA_W-1:0] wb_dat_i = 32'h0000_0000;
	logic [DATA_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic [PINS-1:0] pin_level_i = 16'h0000;
	logic [PINS-1:0] pin_digital_o;
	logic [PINS-1:0] port_read_o;
	logic [MUX_SEL_W-1:0] first_mux_positive_select_o;
	logic first_mux_negative_select_o;
	logic first_mux_ground_o;
	logic [MUX_SEL_W-1:0] second_mux_positive_select_o;
	logic second_mux_negative_select_o;
	logic second_mux_ground_o;
	int err_count = 0;
	int tests_run = 0;

	always #25 clk_i = ~clk_i;

	adis_regs adis_regs_i
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.pin_level_i(pin_level_i),
		.pin_digital_o(pin_digital_o),
		.port_read_o(port_read_o),
		.first_mux_positive_select_o(first_mux_positive_select_o),
		.first_mux_negative_select_o(first_mux_negative_select_o),
		.first_mux_ground_o(first_mux_ground_o),
		.second_mux_positive_select_o(second_mux_positive_select_o),
		.second_mux_negative_select_o(second_mux_negative_select_o),
		.second_mux_ground_o(second_mux_ground_o)
	);

	// ------------------------------------------------------------
	// Reporting.
	// ------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk_word

	task automatic chk_pins(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk_pins

	// ------------------------------------------------------------
	// Wishbone classic single cycles.
	// ------------------------------------------------------------
	task automatic wb_cycle(input logic we, input logic [7:0] adr,
		input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			$display("Error wb_ack_o expected 1 seen %b", wb_ack_o);
			err_count++;
			summarize();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_cycle

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel = SEL_ALL);
		logic [31:0] rd;
		wb_cycle(1'b1, adr, sel, dat, rd);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] adr,
		input logic [31:0] exp);
		logic [31:0] rd;
		wb_cycle(1'b0, adr, SEL_ALL, 32'h0000_0000, rd);
		chk_word(what, exp, rd);
	endtask : rd_chk

	// Lets the configuration outputs and the pin synchroniser settle.
	task automatic settle(input int cycles);
		repeat (cycles) @(posedge clk_i);
		#1;
	endtask : settle

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		settle(1);
		chk_pins("port_read_o", 16'hffff, port_read_o);
		chk_pins("pin_digital_o", 16'h0000, pin_digital_o);
		rd_chk("selection reset", OFS_CHS, 32'h0000_0000);
		rd_chk("pin kind reset", OFS_PIN_KIND_BIT, 32'h0000_0000);
		wr(OFS_CHS, 32'hffff_ffff);
		rd_chk("selection full", OFS_CHS, 32'h8f8f_0000);
		wr(OFS_CHS_CLR, 32'h0f0f_ffff);
		rd_chk("selection clear", OFS_CHS, 32'h8080_0000);
		wr(OFS_CHS_SET, 32'h0102_0000);
		rd_chk("selection set", OFS_CHS, 32'h8182_0000);
		wr(OFS_CHS_INV, 32'h81ff_ffff);
		rd_chk("selection invert", OFS_CHS, 32'h000d_0000);
		wr(OFS_CHS_SET, 32'h0000_0000);
		wr(OFS_CHS_CLR, 32'h0000_0000);
		rd_chk("zero alias", OFS_CHS, 32'h000d_0000);
		rd_chk("clear alias read", OFS_CHS_CLR, 32'h0000_0000);
		rd_chk("invert alias read", OFS_CHS_INV, 32'h0000_0000);
		settle(1);
		chk_pins("first positive", 16'h000d,
			{12'h000, first_mux_positive_select_o});
		chk_pins("first negative", 16'h0000,
			{15'h0000, first_mux_negative_select_o});
		wr(OFS_CHS_INV, 32'h8080_0000);
		settle(2);
		chk_pins("negatives", 16'h0003, {14'h0000,
			first_mux_negative_select_o,
			second_mux_negative_select_o});
		chk_pins("second positive", 16'h0000,
			{12'h000, second_mux_positive_select_o});
		wr(OFS_PIN_KIND_BIT, 32'h0000_0005);
		rd_chk("pin kind write", OFS_PIN_KIND_BIT, 32'h0000_0005);
		wr(OFS_PIN_KIND_BIT_SET, 32'h0000_8000);
		rd_chk("pin kind set", OFS_PIN_KIND_BIT, 32'h0000_8005);
		wr(OFS_PIN_KIND_BIT_CLR, 32'hffff_0001);
		rd_chk("pin kind clear", OFS_PIN_KIND_BIT, 32'h0000_8004);
		rd_chk("pin set alias read", OFS_PIN_KIND_BIT_SET, 32'h0000_0000);
		settle(2);
		chk_pins("ground off", 16'h0000,
			{14'h0000, first_mux_ground_o, second_mux_ground_o});
		wr(OFS_PIN_KIND_BIT_SET, 32'h0000_2000);
		settle(2);
		chk_pins("ground on", 16'h0002,
			{14'h0000, first_mux_ground_o, second_mux_ground_o});
		wr(OFS_PIN_KIND_BIT, 32'h0000_ffff, 4'h1);
		rd_chk("pin kind lane", OFS_PIN_KIND_BIT, 32'h0000_a0ff);
		wr(OFS_PIN_KIND_BIT_SET, 32'h0000_4040, 4'h2);
		rd_chk("set alias lane", OFS_PIN_KIND_BIT, 32'h0000_e0ff);
		wr(8'h1c, 32'hffff_ffff);
		rd_chk("unmapped read", 8'h1c, 32'h0000_0000);
		rd_chk("pin kind kept", OFS_PIN_KIND_BIT, 32'h0000_e0ff);
		@(posedge clk_i);
		pin_level_i <= 16'h5555;
		settle(6);
		chk_pins("pin_digital_o", 16'he0ff, pin_digital_o);
		chk_pins("port_read_o", 16'h5f55, port_read_o);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("pin kind rereset", OFS_PIN_KIND_BIT, 32'h0000_0000);
		settle(1);
		chk_pins("port_read_o rereset", 16'hffff, port_read_o);
		summarize();
	end

endmodule : adis_regs_bench
